// File: rtl/lbc_loop.sv
`timescale 1ns/1ns
`include "lbc_regs.svh"
module lbc_loop (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // bit stream from the exchange side (network direction)
    input wire logic net_rx_bit,
    input wire logic net_rx_valid,
    output logic net_rx_ready,
    input wire logic [1:0] net_rx_slot,
    input wire logic net_rx_frame_start,
    // bit stream towards the user side
    output logic usr_tx_bit,
    output logic usr_tx_valid,
    input wire logic usr_tx_ready,
    // bit stream from the user side
    input wire logic usr_rx_bit,
    // bit stream back towards the exchange
    output logic net_tx_bit,
    // loop 2 control, from layer 1 signals of the exchange
    input wire logic l1_loop2_req,
    input wire logic [1:0] l1_loop2_type,
    input wire logic l1_loop2_transp,
    // loop 3 control, from layer 3 or local maintenance
    input wire logic l3_loop3_req,
    input wire logic [1:0] l3_loop3_if,
    input wire logic [1:0] l3_loop3_type,
    input wire logic l3_loop3_transp,
    input wire logic [2:0] l3_chan_sel,
    input wire logic l3_pattern_bit,
    // which interface the current bit belongs to
    input wire logic [1:0] cur_if,
    // status
    output logic loop2_active,
    output logic [3:0] loop3_active
);

    ////////////////////////////////////////////////////////////////////////
    // decode of whether the current bit lies in a selected channel
    // framing and other overhead slots are never selected, so a partial
    // or logical loop can never corrupt the frame alignment word
    function automatic logic lbc_sel(input logic [1:0] slot, input logic [2:0] sel);
        logic r;
        r = 1'b0;
        unique case (lbc_pkg::lbc_slot_t'(slot))
            lbc_pkg::LBC_SLOT_B1: r = sel[`LBC_CH_B1];
            lbc_pkg::LBC_SLOT_B2: r = sel[`LBC_CH_B2];
            lbc_pkg::LBC_SLOT_D: r = sel[`LBC_CH_D];
            lbc_pkg::LBC_SLOT_OTH: r = 1'b0;
        endcase
        return r;
    endfunction : lbc_sel

    // looped value of one bit for a given loop type
    // the spare type code falls back to the normal user bit, so a bad
    // request can only fail safe, never loop unselected traffic
    function automatic logic lbc_ret(input logic [1:0] ty, input logic inb, input logic insel,
                                     input logic normal);
        logic r;
        r = normal;
        unique case (lbc_pkg::lbc_type_t'(ty))
            lbc_pkg::LBC_COMPLETE: r = inb;
            lbc_pkg::LBC_PARTIAL: r = insel ? inb : normal;
            lbc_pkg::LBC_LOGICAL: r = insel ? (inb ^ `LBC_LOG_XOR) : normal;
            default: r = normal;
        endcase
        return r;
    endfunction : lbc_ret

    ////////////////////////////////////////////////////////////////////////
    // two-entry skid buffer in the user-facing path
    logic [1:0] buf_d_reg, buf_d_next;
    logic [1:0] buf_s_reg, buf_s_next;
    logic [1:0] buf_cnt_reg, buf_cnt_next;
    logic buf_rd_reg, buf_rd_next;
    logic buf_wr_reg, buf_wr_next;

    ////////////////////////////////////////////////////////////////////////
    // loop control state; changes are latched only at frame start
    lbc_pkg::lbc_state_t st_reg, st_next;
    logic [1:0] ty_reg, ty_next;
    logic tr_reg, tr_next;
    logic [1:0] if_reg, if_next;
    logic [2:0] sel_reg, sel_next;
    logic [3:0] l3v_reg, l3v_next;
    logic frm_go;

    assign frm_go = net_rx_valid && net_rx_ready && net_rx_frame_start;

    // loop 2 has priority: it is mandatory and owned by the exchange
    always_comb
    begin
        st_next = st_reg;
        ty_next = ty_reg;
        tr_next = tr_reg;
        if_next = if_reg;
        sel_next = sel_reg;
        l3v_next = l3v_reg;
        if (frm_go)
        begin
            l3v_next = '0;
            if (l1_loop2_req)
            begin
                st_next = lbc_pkg::LBC_ST_LOOP2;
                ty_next = l1_loop2_type;
                tr_next = l1_loop2_transp;
                sel_next = 3'h7;
            end
            else if (l3_loop3_req)
            begin
                st_next = lbc_pkg::LBC_ST_LOOP3;
                ty_next = l3_loop3_type;
                tr_next = l3_loop3_transp;
                if_next = l3_loop3_if;
                sel_next = l3_chan_sel;
                l3v_next[l3_loop3_if] = 1'b1;
            end
            else
            begin
                st_next = lbc_pkg::LBC_ST_IDLE;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= lbc_pkg::LBC_ST_IDLE;
            ty_reg <= 2'h0;
            tr_reg <= 1'b1;
            if_reg <= 2'h0;
            sel_reg <= 3'h0;
            l3v_reg <= 4'h0;
        end
        else
        begin
            st_reg <= st_next;
            ty_reg <= ty_next;
            tr_reg <= tr_next;
            if_reg <= if_next;
            sel_reg <= sel_next;
            l3v_reg <= l3v_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-bit datapath
    logic in_sel, looping, here, fwd_bit, ret_bit;
    logic net_tx_reg, net_tx_next;
    logic [1:0] st_oh_unused;

    assign looping = (st_reg != lbc_pkg::LBC_ST_IDLE);
    // loop 3 only applies to bits of the addressed interface
    assign here = (st_reg == lbc_pkg::LBC_ST_LOOP2) ||
                  ((st_reg == lbc_pkg::LBC_ST_LOOP3) && (cur_if == if_reg));
    assign in_sel = lbc_sel(net_rx_slot, sel_reg) || (ty_reg == 2'h0);

    always_comb
    begin
        // return path: looped bits go back, others keep the normal user stream
        ret_bit = usr_rx_bit;
        if (looping && here)
            ret_bit = lbc_ret(ty_reg, net_rx_bit, in_sel, usr_rx_bit);
        // forward path: transparent copies, non-transparent substitutes
        fwd_bit = net_rx_bit;
        if (looping && here && in_sel && !tr_reg)
            fwd_bit = (st_reg == lbc_pkg::LBC_ST_LOOP3) ? l3_pattern_bit : `LBC_SUB_PAT;
        net_tx_next = net_tx_reg;
        if (net_rx_valid && net_rx_ready)
            net_tx_next = ret_bit;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            net_tx_reg <= 1'b1;
        else
            net_tx_reg <= net_tx_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // buffer next-state: push forward bits, pop to user side
    logic push, pop;
    assign push = net_rx_valid && buf_wr_reg;
    assign pop = buf_rd_reg && usr_tx_ready;

    always_comb
    begin
        buf_d_next = buf_d_reg;
        buf_s_next = buf_s_reg;
        buf_cnt_next = buf_cnt_reg;
        if (pop)
        begin
            buf_d_next = {1'b0, buf_d_reg[1]};
            buf_cnt_next = buf_cnt_reg - 2'h1;
        end
        if (push)
        begin
            buf_d_next[buf_cnt_next[0]] = fwd_bit;
            buf_cnt_next = buf_cnt_next + 2'h1;
        end
        buf_s_next = buf_cnt_next;
        buf_rd_next = (buf_cnt_next != 2'h0);
        buf_wr_next = (buf_cnt_next != 2'h2); // stall stays honest at two
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            buf_d_reg <= 2'h3;
            buf_s_reg <= 2'h0;
            buf_cnt_reg <= 2'h0;
            buf_rd_reg <= 1'b0;
            buf_wr_reg <= 1'b1;
        end
        else
        begin
            buf_d_reg <= buf_d_next;
            buf_s_reg <= buf_s_next;
            buf_cnt_reg <= buf_cnt_next;
            buf_rd_reg <= buf_rd_next;
            buf_wr_reg <= buf_wr_next;
        end
    end

    assign st_oh_unused = buf_s_reg;
    assign net_rx_ready = buf_wr_reg;
    assign usr_tx_valid = buf_rd_reg;
    assign usr_tx_bit = buf_d_reg[0];
    assign net_tx_bit = net_tx_reg;
    assign loop2_active = st_reg[1];
    assign loop3_active = l3v_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_complete_returns: assert property (@(posedge clk) disable iff (!arst_n)
        (st_reg == lbc_pkg::LBC_ST_LOOP2 && ty_reg == 2'h0 && net_rx_valid && net_rx_ready)
        |=> net_tx_bit == $past(net_rx_bit)) else $error("complete loop altered bit");
    a_partial_other: assert property (@(posedge clk) disable iff (!arst_n)
        (looping && here && ty_reg == 2'h1 && !in_sel && net_rx_valid && net_rx_ready)
        |=> net_tx_bit == $past(usr_rx_bit)) else $error("partial loop took unselected bit");
    a_logical_mod: assert property (@(posedge clk) disable iff (!arst_n)
        (looping && here && ty_reg == 2'h2 && in_sel && net_rx_valid && net_rx_ready)
        |=> net_tx_bit != $past(net_rx_bit)) else $error("logical loop not modified");
    a_transp_fwd: assert property (@(posedge clk) disable iff (!arst_n)
        (tr_reg && push && buf_cnt_reg == 2'h0) |=> usr_tx_bit == $past(net_rx_bit))
        else $error("transparent forward differs");
    a_nontransp_sub: assert property (@(posedge clk) disable iff (!arst_n)
        (st_reg == lbc_pkg::LBC_ST_LOOP2 && !tr_reg && in_sel && push && buf_cnt_reg == 2'h0)
        |=> usr_tx_bit == `LBC_SUB_PAT) else $error("substitute missing");
    a_loop2_prio: assert property (@(posedge clk) disable iff (!arst_n)
        (frm_go && l1_loop2_req) |=> loop2_active && loop3_active == 4'h0)
        else $error("loop 2 not taken");
    a_loop3_one_if: assert property (@(posedge clk) disable iff (!arst_n)
        (frm_go && !l1_loop2_req && l3_loop3_req) |=> $onehot(loop3_active))
        else $error("loop 3 not per interface");
    a_frame_edge: assert property (@(posedge clk) disable iff (!arst_n)
        !frm_go |=> $stable(st_reg)) else $error("loop changed mid frame");

    ////////////////////////////////////////////////////////////////////////
    // further checks on the looped channels, the idle path and the buffer

    // selected bits of a partial loop come back untouched
    a_partial_sel: assert property (@(posedge clk) disable iff (!arst_n)
        (looping && here && ty_reg == 2'h1 && in_sel && net_rx_valid && net_rx_ready)
        |=> net_tx_bit == $past(net_rx_bit)) else $error("partial loop altered selected bit");

    // with no loop the user stream goes back to the exchange
    a_idle_pass: assert property (@(posedge clk) disable iff (!arst_n)
        (st_reg == lbc_pkg::LBC_ST_IDLE && net_rx_valid && net_rx_ready)
        |=> net_tx_bit == $past(usr_rx_bit)) else $error("idle path not normal");

    // non-transparent loop 3 forwards the locally made pattern
    a_loop3_pattern: assert property (@(posedge clk) disable iff (!arst_n)
        (st_reg == lbc_pkg::LBC_ST_LOOP3 && here && in_sel && !tr_reg && push && buf_cnt_reg == 2'h0)
        |=> usr_tx_bit == $past(l3_pattern_bit)) else $error("loop 3 pattern missing");

    // loop 3 lands on the interface that the request named
    a_loop3_target: assert property (@(posedge clk) disable iff (!arst_n)
        (frm_go && !l1_loop2_req && l3_loop3_req) |=> loop3_active[$past(l3_loop3_if)])
        else $error("loop 3 on wrong interface");

    // no loop state may linger once the block is idle
    a_idle_clear: assert property (@(posedge clk) disable iff (!arst_n)
        (st_reg == lbc_pkg::LBC_ST_IDLE) |-> (loop3_active == 4'h0 && !loop2_active))
        else $error("loop flag left while idle");

    // the buffer holds two entries at most
    a_buf_bound: assert property (@(posedge clk) disable iff (!arst_n)
        buf_cnt_reg != 2'h3)
        else $error("buffer count out of range");

    // a full buffer must refuse the next bit, or a stall would lose it
    a_buf_full: assert property (@(posedge clk) disable iff (!arst_n)
        (buf_cnt_reg == 2'h2) |-> !net_rx_ready)
        else $error("full buffer still ready");

    // an empty buffer must not offer a bit to the user side
    a_buf_empty: assert property (@(posedge clk) disable iff (!arst_n)
        (buf_cnt_reg == 2'h0) |-> !usr_tx_valid)
        else $error("empty buffer shows valid");

endmodule : lbc_loop

// File: rtl/lbc_pkg.sv
package lbc_pkg;
    // loopback type
    typedef enum logic [1:0] {
        LBC_COMPLETE = 2'h0,
        LBC_PARTIAL = 2'h1,
        LBC_LOGICAL = 2'h2
    } lbc_type_t;
    // channel that the current bit belongs to
    typedef enum logic [1:0] {
        LBC_SLOT_B1 = 2'h0,
        LBC_SLOT_B2 = 2'h1,
        LBC_SLOT_D = 2'h2,
        LBC_SLOT_OTH = 2'h3
    } lbc_slot_t;
    // loop state machine, one-hot
    typedef enum logic [2:0] {
        LBC_ST_IDLE = 3'h1,
        LBC_ST_LOOP2 = 3'h2,
        LBC_ST_LOOP3 = 3'h4
    } lbc_state_t;
endpackage : lbc_pkg

// File: rtl/lbc_regs.svh
`ifndef LBC_REGS_SVH
`define LBC_REGS_SVH

// frame geometry: 48 bits per frame, 4 channel slots of 2B+D
`define LBC_FRAME_BITS 48
`define LBC_NUM_IF 4
// channel select bits
`define LBC_CH_B1 0
`define LBC_CH_B2 1
`define LBC_CH_D 2
// substitute pattern for non-transparent loop 2 forward path (loop 3 uses l3_pattern_bit)
`define LBC_SUB_PAT 1'b1
// logical loop modification mask (inverts looped bit)
`define LBC_LOG_XOR 1'b1

`endif

// File: tb/lbc_exch_model.sv
`timescale 1ns/1ns
module lbc_exch_model (
    // clock
    input wire logic clk,
    // stream into the loop block
    output logic net_rx_bit,
    output logic net_rx_valid,
    input wire logic net_rx_ready,
    output logic [1:0] net_rx_slot,
    output logic net_rx_frame_start
);
    // idle line
    initial
    begin
        net_rx_bit = 1'b0;
        net_rx_valid = 1'b0;
        net_rx_slot = 2'h3;
        net_rx_frame_start = 1'b0;
    end
    ////////////////////////////////////////
    // one bit per beat, held until ready; then the line shows the inverse so a stale bit never passes
    task automatic send(input logic b, input logic [1:0] s, input logic fs);
        @(posedge clk);
        net_rx_bit <= b;
        net_rx_slot <= s;
        net_rx_frame_start <= fs;
        net_rx_valid <= 1'b1;
        do
            @(posedge clk);
        while (net_rx_ready !== 1'b1);
        net_rx_valid <= 1'b0;
        net_rx_bit <= ~b;
        net_rx_frame_start <= 1'b0;
    endtask : send
endmodule : lbc_exch_model

// File: tb/lbc_loop_bench.sv
`timescale 1ns/1ns
module lbc_loop_bench;
    logic clk = 1'b0, arst_n = 1'b0;
    logic nrb, nrv, nrr, nrfs, utb, utv, utr = 1'b0, urb = 1'b0, ntb;
    logic [1:0] nrs, l2t = 2'h0, l3i = 2'h0, l3t = 2'h0, cif = 2'h0;
    logic l2r = 1'b0, l2p = 1'b1, l3r = 1'b0, l3p = 1'b1, l3pb = 1'b0;
    logic [2:0] l3c = 3'h0;
    logic l2a;
    logic [3:0] l3a;
    int err_count = 0, checked = 0, cyc = 0;
    // clock and watchdog
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            results();
        end
    end
    lbc_exch_model ex (.clk(clk), .net_rx_bit(nrb), .net_rx_valid(nrv), .net_rx_ready(nrr),
        .net_rx_slot(nrs), .net_rx_frame_start(nrfs));
    lbc_loop dut (.clk(clk), .arst_n(arst_n), .net_rx_bit(nrb), .net_rx_valid(nrv), .net_rx_ready(nrr),
        .net_rx_slot(nrs), .net_rx_frame_start(nrfs), .usr_tx_bit(utb), .usr_tx_valid(utv),
        .usr_tx_ready(utr), .usr_rx_bit(urb), .net_tx_bit(ntb), .l1_loop2_req(l2r), .l1_loop2_type(l2t),
        .l1_loop2_transp(l2p), .l3_loop3_req(l3r), .l3_loop3_if(l3i), .l3_loop3_type(l3t),
        .l3_loop3_transp(l3p), .l3_chan_sel(l3c), .l3_pattern_bit(l3pb), .cur_if(cif),
        .loop2_active(l2a), .loop3_active(l3a));
    ////////////////////////////////////////
    // compare and count
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // one bit in with the user bit u; judge the return and the forward, then pop the buffer
    task automatic beat(input logic b, input logic [1:0] s, input logic fs, input logic u,
        input logic et, input logic ef);
        @(posedge clk);
        urb <= u;
        ex.send(b, s, fs);
        @(posedge clk);
        #1;
        chk(ntb, et);
        chk(utv, 1'b1);
        chk(utb, ef);
        @(posedge clk);
        utr <= 1'b1;
        @(posedge clk);
        utr <= 1'b0;
    endtask : beat
    task automatic results;
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    ////////////////////////////////////////
    // loop 2 complete type transparent and not, then logical type transparent; the frame-start bit still uses the old setting
    task automatic t_loop2;
        @(posedge clk);
        l2r <= 1'b1;
        beat(1'b1, 2'h3, 1'b1, 1'b0, 1'b0, 1'b1);
        chk(l2a, 1'b1);
        beat(1'b0, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0);
        beat(1'b1, 2'h2, 1'b0, 1'b0, 1'b1, 1'b1);
        l2p <= 1'b0;
        beat(1'b0, 2'h3, 1'b1, 1'b1, 1'b0, 1'b0);
        beat(1'b0, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        l2t <= 2'h2;
        l2p <= 1'b1;
        beat(1'b1, 2'h3, 1'b1, 1'b0, 1'b1, 1'b1);
        beat(1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
        l2r <= 1'b0;
        beat(1'b0, 2'h3, 1'b1, 1'b1, 1'b1, 1'b0);
        chk(l2a, 1'b0);
        l2r <= 1'b1;
        beat(1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
        chk(l2a, 1'b0);
        l2r <= 1'b0;
        $display("loop2 test done");
    endtask : t_loop2
    // partial non-transparent loop 3 on one interface, then loop 2 taking over
    task automatic t_loop3;
        @(posedge clk);
        {cif, l3r, l3i, l3t, l3p, l3c} <= {2'h2, 1'b1, 2'h2, 2'h1, 1'b0, 3'h1};
        beat(1'b1, 2'h3, 1'b1, 1'b0, 1'b0, 1'b1);
        chk(l3a, 4'h4);
        beat(1'b1, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0);
        beat(1'b1, 2'h1, 1'b0, 1'b0, 1'b0, 1'b1);
        cif <= 2'h1;
        beat(1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
        {l2r, l2t} <= {1'b1, 2'h0};
        beat(1'b0, 2'h3, 1'b1, 1'b1, 1'b1, 1'b0);
        chk({l2a, l3a}, 5'h10);
        {l2r, l3r} <= 2'h0;
        beat(1'b1, 2'h3, 1'b1, 1'b0, 1'b1, 1'b1);
        $display("loop3 test done");
    endtask : t_loop3
    // two bits held while the user side stalls, then drained in order
    task automatic t_buffer;
        ex.send(1'b1, 2'h0, 1'b0);
        ex.send(1'b0, 2'h0, 1'b0);
        @(posedge clk);
        #1;
        chk({nrr, utv, utb}, 3'h3);
        @(posedge clk);
        utr <= 1'b1;
        @(posedge clk);
        utr <= 1'b0;
        #1;
        chk({nrr, utv, utb}, 3'h6);
        @(posedge clk);
        utr <= 1'b1;
        @(posedge clk);
        utr <= 1'b0;
        #1;
        chk({nrr, utv}, 2'h2);
        $display("buffer test done");
    endtask : t_buffer
    ////////////////////////////////////////
    // reset, idle values, normal paths, then the loops and the buffer
    initial
    begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk({ntb, utv, utb, nrr, l2a, l3a}, 9'h160);
        beat(1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
        beat(1'b0, 2'h1, 1'b0, 1'b1, 1'b1, 1'b0);
        $display("normal test done");
        t_loop2();
        t_loop3();
        t_buffer();
        results();
    end
endmodule : lbc_loop_bench
